// ==== include/nbf_pkg.sv ====
// Package of the NAND bus front-end host controller: opcodes, register map, timing.
// Assumes a 40 MHz system clock and one 8-bit multiplexed NAND device on the pins.
package nbf_pkg;
    // Device opcodes
    localparam logic [7:0] OPC_RESET = 8'hff;
    localparam logic [7:0] OPC_READ1 = 8'h00;
    localparam logic [7:0] OPC_READ2 = 8'h30;
    localparam logic [7:0] OPC_RND1 = 8'h05;
    localparam logic [7:0] OPC_RND2 = 8'he0;
    localparam logic [7:0] OPC_STATUS = 8'h70;
    localparam logic [7:0] OPC_PROG1 = 8'h80;
    localparam logic [7:0] OPC_PROG2 = 8'h10;
    localparam logic [7:0] OPC_ERASE1 = 8'h60;
    localparam logic [7:0] OPC_ERASE2 = 8'hd0;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_OP = 5'h04;
    localparam logic [4:0] OFS_COL = 5'h08;
    localparam logic [4:0] OFS_ROW = 5'h0c;
    localparam logic [4:0] OFS_LEN = 5'h10;
    localparam logic [4:0] OFS_WDATA = 5'h14;
    localparam logic [4:0] OFS_STAT = 5'h18;
    // Field positions and reset values
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_RB_BIT = 9;
    localparam int STAT_REFUSED_BIT = 10;
    localparam int STAT_WPEND_BIT = 11;
    localparam logic CTRL_WP_N_RST = 1'b0;
    localparam logic [11:0] LEN_RST = 12'h000;
    // Timing
    localparam int CLK_NS = 25;
    localparam int T_WB_NS = 100;
    localparam int T_RE_LOW_NS = 100;
    localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
    localparam int RE_LOW_CYC = (T_RE_LOW_NS + CLK_NS - 1) / CLK_NS;
    // Operations that software may start
    typedef enum logic [2:0] {
        OP_RESET = 3'b000,
        OP_READ = 3'b001,
        OP_RNDOUT = 3'b010,
        OP_STATUS = 3'b011,
        OP_PROG = 3'b100,
        OP_ERASE = 3'b101
    } nbf_op_t;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD1 = 3'b001,
        ST_ADDR = 3'b010,
        ST_WDAT = 3'b011,
        ST_CMD2 = 3'b100,
        ST_WAIT = 3'b101,
        ST_RDAT = 3'b110
    } nbf_st_t;
endpackage : nbf_pkg

// ==== design/nbf_host.sv ====
// Host controller for an 8-bit multiplexed NAND flash bus, with a register port and read stream.
// Assumes one device on the pins, ready/busy pulled up outside, tri-state resolved by the bench.
// Behaviour
// [R1] Busy device keeps chip select low
// [R2] Each read strobe fall yields one byte
// [R3] Bytes latched at write strobe rising edge
// [R4] Command latch high marks command bytes
// [R5] Address latch high marks address cycles
// [R6] Write guard low forbids program, erase
// [R7] Ready/busy low while device is working
// [R8] Ready/busy open drain, keeps its state
// [R9] IO lines driven only by writer
// [R10] Column sent in two cycles, upper zero
// [R11] Row: page bits low, block bits high
// [R12] Random data moves only within page
// [R13] Only defined opcodes are ever issued
// [R14] Reset opcode aborts and clears device
// [R15] Page read: 00h, four addresses, 30h
// [R16] After 70h reads return status byte
// [R17] Random out: 05h, two columns, E0h
// [R18] Busy device takes only reset, status
// [R19] Data out: latches low, write high
`timescale 1ns/1ps
module nbf_host #(
    parameter int LEN_W = 12
) (
    input wire logic clk_sys_in,            // System clock, 40 MHz
    input wire logic reset_in,              // Async reset, active high
    input wire logic clk_en_in,             // Freezes all state when low
    input wire logic [4:0] reg_addr_in,     // Register byte address
    input wire logic [31:0] reg_wdata_in,   // Register write data
    input wire logic reg_wr_in,             // Write strobe
    input wire logic reg_rd_in,             // Read strobe
    output logic [31:0] reg_rdata_out,      // Read data, cycle after strobe
    output logic [7:0] rd_data_out,         // Read stream byte
    output logic rd_valid_out,              // Read stream byte valid
    input wire logic rd_ready_in,           // Read stream consumer ready
    output logic cle_out,                   // Command latch qualifier
    output logic ale_out,                   // Address latch qualifier
    output logic ce_n_out,                  // Chip select, active low
    output logic we_n_out,                  // Write strobe, active low
    output logic read_strobe_n_out,         // Read strobe, active low
    output logic wp_n_out,                  // Write guard, active low
    input wire logic ready_busy_n_in,       // Device ready, low when busy
    input wire logic [7:0] io_bus_in,       // IO lines, input
    output logic [7:0] io_bus_out,          // IO lines, output
    output logic io_bus_oe_out              // IO lines, output enable
);
    typedef struct packed {
        nbf_pkg::nbf_st_t st;
        nbf_pkg::nbf_op_t op;
        logic [3:0] ph;
        logic [LEN_W-1:0] cnt;
        logic [1:0] idx;
        logic [2:0] rb_s;
        logic rb;
        logic [7:0] io_s1;
        logic [7:0] io_s2;
        logic [7:0] io_s3;
        logic wp_n;
        logic [11:0] col;
        logic [15:0] row;
        logic [LEN_W-1:0] len;
        logic [7:0] wdat;
        logic wpend;
        logic [7:0] last;
        logic refused;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [1:0] bcnt;
        logic [31:0] rdata;
        logic cle;
        logic ale;
        logic ce_n;
        logic we_n;
        logic re_n;
        logic oe;
        logic [7:0] dout;
    } nbf_host_state_t;

    nbf_host_state_t q, d;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode and address tables

    // First opcode of each operation
    function automatic logic [7:0] opc1(input nbf_pkg::nbf_op_t op);
        unique case (op)
            nbf_pkg::OP_READ: opc1 = nbf_pkg::OPC_READ1;
            nbf_pkg::OP_RNDOUT: opc1 = nbf_pkg::OPC_RND1;
            nbf_pkg::OP_STATUS: opc1 = nbf_pkg::OPC_STATUS;
            nbf_pkg::OP_PROG: opc1 = nbf_pkg::OPC_PROG1;
            nbf_pkg::OP_ERASE: opc1 = nbf_pkg::OPC_ERASE1;
            default: opc1 = nbf_pkg::OPC_RESET;
        endcase
    endfunction : opc1

    // Confirming opcode of two-cycle operations
    function automatic logic [7:0] opc2(input nbf_pkg::nbf_op_t op);
        unique case (op)
            nbf_pkg::OP_READ: opc2 = nbf_pkg::OPC_READ2;
            nbf_pkg::OP_RNDOUT: opc2 = nbf_pkg::OPC_RND2;
            nbf_pkg::OP_PROG: opc2 = nbf_pkg::OPC_PROG2;
            default: opc2 = nbf_pkg::OPC_ERASE2;
        endcase
    endfunction : opc2

    // Address byte per cycle index: column low, column high, row low, row high
    function automatic logic [7:0] addr_byte(input logic [1:0] i, input logic [11:0] c, input logic [15:0] r);
        unique case (i)
            2'd0: addr_byte = c[7:0];
            2'd1: addr_byte = {4'h0, c[11:8]};                  // [R10]
            2'd2: addr_byte = r[7:0];                           // [R11]
            default: addr_byte = r[15:8];
        endcase
    endfunction : addr_byte

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic op_wr, pop, push, op_bad;
    nbf_pkg::nbf_op_t op_new;

    always_comb begin
        d = q;
        op_wr = reg_wr_in && reg_addr_in == nbf_pkg::OFS_OP;
        op_new = nbf_pkg::nbf_op_t'(reg_wdata_in[2:0]);
        push = 1'b0;
        pop = q.bcnt != 2'd0 && rd_ready_in;
        // Three-stage pin synchronisers, change taken when stages two and three agree
        d.rb_s = {q.rb_s[1:0], ready_busy_n_in};
        if (q.rb_s[1] == q.rb_s[2]) begin
            d.rb = q.rb_s[2];
        end
        d.io_s1 = io_bus_in;
        d.io_s2 = q.io_s1;
        d.io_s3 = q.io_s2;
        // Refusal of illegal, guarded or busy-time requests
        op_bad = q.st != nbf_pkg::ST_IDLE || reg_wdata_in[2:0] > 3'd5;                        // [R13]
        if ((op_new == nbf_pkg::OP_PROG || op_new == nbf_pkg::OP_ERASE) && !q.wp_n) begin
            op_bad = 1'b1;                                                                  // [R6]
        end
        if (!q.rb && op_new != nbf_pkg::OP_RESET && op_new != nbf_pkg::OP_STATUS) begin
            op_bad = 1'b1;                                                                  // [R18]
        end
        // Register writes
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                nbf_pkg::OFS_CTRL: d.wp_n = reg_wdata_in[0];
                nbf_pkg::OFS_COL: d.col = reg_wdata_in[11:0];
                nbf_pkg::OFS_ROW: d.row = reg_wdata_in[15:0];
                nbf_pkg::OFS_LEN: d.len = reg_wdata_in[LEN_W-1:0];
                nbf_pkg::OFS_WDATA: begin
                    d.wdat = reg_wdata_in[7:0];
                    d.wpend = 1'b1;
                end
                nbf_pkg::OFS_STAT: if (reg_wdata_in[nbf_pkg::STAT_REFUSED_BIT]) d.refused = 1'b0;
                default: ;
            endcase
        end
        // Sequencer
        unique case (q.st)
            nbf_pkg::ST_IDLE: begin
                if (op_wr && !op_bad) begin
                    d.st = nbf_pkg::ST_CMD1;
                    d.op = op_new;
                    d.ph = 4'd0;
                    d.cnt = '0;
                end
            end
            nbf_pkg::ST_CMD1: begin
                d.ph = 4'd1;
                if (q.ph == 4'd1) begin
                    d.ph = 4'd0;
                    unique case (q.op)
                        nbf_pkg::OP_RESET: d.st = nbf_pkg::ST_WAIT;                          // [R14]
                        nbf_pkg::OP_STATUS: d.st = nbf_pkg::ST_RDAT;                         // [R16]
                        nbf_pkg::OP_ERASE: begin
                            d.st = nbf_pkg::ST_ADDR;
                            d.idx = 2'd2;
                        end
                        default: begin
                            d.st = nbf_pkg::ST_ADDR;
                            d.idx = 2'd0;
                        end
                    endcase
                end
            end
            nbf_pkg::ST_ADDR: begin
                d.ph = 4'd1;
                if (q.ph == 4'd1) begin
                    d.ph = 4'd0;
                    d.idx = q.idx + 2'd1;
                    if (q.idx == 2'd3 || (q.op == nbf_pkg::OP_RNDOUT && q.idx == 2'd1)) begin   // [R15] [R17] [R12]
                        d.st = (q.op == nbf_pkg::OP_PROG && q.len != '0) ? nbf_pkg::ST_WDAT : nbf_pkg::ST_CMD2;
                    end
                end
            end
            nbf_pkg::ST_WDAT: begin
                if (q.ph == 4'd0 && q.wpend) begin
                    d.ph = 4'd1;
                    d.dout = q.wdat;
                    d.wpend = reg_wr_in && reg_addr_in == nbf_pkg::OFS_WDATA;
                end else if (q.ph == 4'd1) begin
                    d.ph = 4'd0;
                    d.cnt = q.cnt + 1'b1;
                    if (q.cnt + 1'b1 == q.len) begin
                        d.st = nbf_pkg::ST_CMD2;
                    end
                end
            end
            nbf_pkg::ST_CMD2: begin
                d.ph = 4'd1;
                if (q.ph == 4'd1) begin
                    d.ph = 4'd0;
                    d.st = (q.op == nbf_pkg::OP_RNDOUT) ? nbf_pkg::ST_RDAT : nbf_pkg::ST_WAIT;
                end
            end
            nbf_pkg::ST_WAIT: begin
                if (q.ph != 4'(nbf_pkg::WB_CYC)) begin
                    d.ph = q.ph + 4'd1;
                end else if (q.rb) begin                                                    // [R7]
                    d.ph = 4'd0;
                    d.cnt = '0;
                    d.st = (q.op == nbf_pkg::OP_READ) ? nbf_pkg::ST_RDAT : nbf_pkg::ST_IDLE;
                end
            end
            nbf_pkg::ST_RDAT: begin
                if (q.op != nbf_pkg::OP_STATUS && q.len == '0) begin
                    d.st = nbf_pkg::ST_IDLE;
                end else if (q.ph == 4'd0) begin
                    if (q.bcnt != 2'd2) d.ph = 4'd1;
                end else if (q.ph != 4'(nbf_pkg::RE_LOW_CYC)) begin
                    d.ph = q.ph + 4'd1;
                end else if (q.io_s2 == q.io_s3) begin
                    push = 1'b1;                                                            // [R2]
                    d.last = q.io_s3;
                    d.ph = 4'd0;
                    d.cnt = q.cnt + 1'b1;
                    if (q.op == nbf_pkg::OP_STATUS || q.cnt + 1'b1 == q.len) begin
                        d.st = nbf_pkg::ST_IDLE;
                    end
                end
            end
            default: d.st = nbf_pkg::ST_IDLE;
        endcase
        // Refused flag: a new refusal wins over the clear
        if (op_wr && op_bad) d.refused = 1'b1;
        // Two-entry read buffer
        unique case ({push, pop})
            2'b10: begin
                if (q.bcnt == 2'd0) d.b0 = q.io_s3;
                else d.b1 = q.io_s3;
                d.bcnt = q.bcnt + 2'd1;
            end
            2'b01: begin
                d.b0 = q.b1;
                d.bcnt = q.bcnt - 2'd1;
            end
            2'b11: begin
                if (q.bcnt == 2'd1) d.b0 = q.io_s3;
                else begin
                    d.b0 = q.b1;
                    d.b1 = q.io_s3;
                end
            end
            default: ;
        endcase
        // Register read data
        d.rdata = 32'h0;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                nbf_pkg::OFS_CTRL: d.rdata[0] = q.wp_n;
                nbf_pkg::OFS_OP: d.rdata[2:0] = q.op;
                nbf_pkg::OFS_COL: d.rdata[11:0] = q.col;
                nbf_pkg::OFS_ROW: d.rdata[15:0] = q.row;
                nbf_pkg::OFS_LEN: d.rdata[LEN_W-1:0] = q.len;
                nbf_pkg::OFS_WDATA: d.rdata[7:0] = q.wdat;
                nbf_pkg::OFS_STAT: begin
                    d.rdata[7:0] = q.last;
                    d.rdata[nbf_pkg::STAT_BUSY_BIT] = q.st != nbf_pkg::ST_IDLE;
                    d.rdata[nbf_pkg::STAT_RB_BIT] = q.rb;
                    d.rdata[nbf_pkg::STAT_REFUSED_BIT] = q.refused;
                    d.rdata[nbf_pkg::STAT_WPEND_BIT] = q.wpend;
                end
                default: ;
            endcase
        end
        // Pin levels for the next state
        d.ce_n = d.st == nbf_pkg::ST_IDLE;                                                   // [R1]
        d.cle = d.st == nbf_pkg::ST_CMD1 || d.st == nbf_pkg::ST_CMD2;                        // [R4]
        d.ale = d.st == nbf_pkg::ST_ADDR;                                                    // [R5]
        d.we_n = !((d.cle || d.ale || d.st == nbf_pkg::ST_WDAT) && d.ph == 4'd0 &&
                   (d.st != nbf_pkg::ST_WDAT || d.wpend));
        d.re_n = !(d.st == nbf_pkg::ST_RDAT && d.ph != 4'd0);                                // [R19]
        d.oe = d.cle || d.ale || d.st == nbf_pkg::ST_WDAT;                                   // [R9]
        if (d.st == nbf_pkg::ST_CMD1) d.dout = opc1(d.op);
        else if (d.st == nbf_pkg::ST_CMD2) d.dout = opc2(d.op);
        else if (d.st == nbf_pkg::ST_ADDR) d.dout = addr_byte(d.idx, d.col, d.row);
        else if (d.st == nbf_pkg::ST_WDAT && d.ph == 4'd0) d.dout = d.wdat;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            q <= '0;
            q.rb_s <= 3'b111;
            q.rb <= 1'b1;
            q.wp_n <= nbf_pkg::CTRL_WP_N_RST;
            q.len <= LEN_W'(nbf_pkg::LEN_RST);
            q.ce_n <= 1'b1;
            q.we_n <= 1'b1;
            q.re_n <= 1'b1;
        end else if (clk_en_in) begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops, except rd_valid_out decoded from the buffer count
    assign reg_rdata_out = q.rdata;
    assign rd_data_out = q.b0;
    assign rd_valid_out = q.bcnt != 2'd0;
    assign cle_out = q.cle;
    assign ale_out = q.ale;
    assign ce_n_out = q.ce_n;
    assign we_n_out = q.we_n;
    assign read_strobe_n_out = q.re_n;
    assign wp_n_out = q.wp_n;
    assign io_bus_out = q.dout;
    assign io_bus_oe_out = q.oe;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    logic [LEN_W-1:0] cnt_w;
    nbf_pkg::nbf_st_t st_w;
    assign cnt_w = q.cnt;
    assign st_w = q.st;

    default clocking cb @(posedge clk_sys_in iff clk_en_in); endclocking
    default disable iff (reset_in);

    property p_wait_ce; st_w == nbf_pkg::ST_WAIT |-> !ce_n_out; endproperty
    a_wait_ce: assert property (p_wait_ce) else $error("chip select released while waiting"); // [R1]
    property p_re_step; $rose(read_strobe_n_out) |-> cnt_w == $past(cnt_w) + 1'b1; endproperty
    a_re_step: assert property (p_re_step) else $error("read strobe did not step count"); // [R2]
    property p_we_hold; $rose(we_n_out) |-> io_bus_oe_out && $stable(io_bus_out); endproperty
    a_we_hold: assert property (p_we_hold) else $error("data moved at write strobe rise"); // [R3]
    property p_cle_cmd; cle_out |-> !ale_out && (io_bus_out == opc1(q.op) || io_bus_out == opc2(q.op)); endproperty
    a_cle_cmd: assert property (p_cle_cmd) else $error("command cycle without opcode"); // [R4]
    property p_col_hi; ale_out && q.idx == 2'd1 |-> io_bus_out == {4'h0, q.col[11:8]}; endproperty
    a_col_hi: assert property (p_col_hi) else $error("second column byte wrong"); // [R10]
    property p_guard; st_w != nbf_pkg::ST_IDLE && (q.op == nbf_pkg::OP_PROG || q.op == nbf_pkg::OP_ERASE)
        |-> wp_n_out; endproperty
    a_guard: assert property (p_guard) else $error("program or erase under write guard"); // [R6]
    property p_rb_wait; st_w == nbf_pkg::ST_WAIT && q.ph == 4'(nbf_pkg::WB_CYC) && !q.rb
        |=> st_w == nbf_pkg::ST_WAIT; endproperty
    a_rb_wait: assert property (p_rb_wait) else $error("left wait while device busy"); // [R7]
    property p_oe_read; !read_strobe_n_out |-> !io_bus_oe_out; endproperty
    a_oe_read: assert property (p_oe_read) else $error("driving IO during read"); // [R9]
    property p_busy_ref; reg_wr_in && reg_addr_in == nbf_pkg::OFS_OP && !q.rb && reg_wdata_in[2:0] == 3'd1
        |=> q.refused && st_w == $past(st_w); endproperty
    a_busy_ref: assert property (p_busy_ref) else $error("busy device given read"); // [R18]
    property p_rd_seq; st_w == nbf_pkg::ST_CMD2 && q.op == nbf_pkg::OP_READ
        |-> io_bus_out == nbf_pkg::OPC_READ2 ##2 st_w == nbf_pkg::ST_WAIT; endproperty
    a_rd_seq: assert property (p_rd_seq) else $error("page read confirm wrong"); // [R15]
    property p_dout_pins; !read_strobe_n_out |-> !cle_out && !ale_out && !ce_n_out && we_n_out; endproperty
    a_dout_pins: assert property (p_dout_pins) else $error("bad pins during data out"); // [R19]
endmodule : nbf_host

// ==== tb/nbf_dev_model.sv ====
// Behavioural NAND device on the far side of the host controller.
// Assumes the bench resolves the io wire and pulls ready/busy up.
`timescale 1ns/1ps
module nbf_dev_model #(
    parameter int BUSY_NS = 2000 // Array operation time
) (
    input wire logic cle_in,            // Command latch qualifier
    input wire logic ale_in,            // Address latch qualifier
    input wire logic ce_n_in,           // Chip select, active low
    input wire logic we_n_in,           // Write strobe, active low
    input wire logic read_strobe_n_in,  // Read strobe, active low
    input wire logic wp_n_in,           // Write guard, active low
    input wire logic [7:0] io_bus_in,   // Resolved io lines
    output logic [7:0] io_bus_out,      // Device drive value
    output logic io_bus_oe_out,         // Device drives io lines
    output logic rb_low_out             // Pulls ready/busy low
);
    logic [7:0] arr [int];
    logic [7:0] pend [int];
    logic [7:0] a [4];
    logic [11:0] col;
    logic stat_mode;
    logic fail;
    int na;
    realtime busy_until;
    ////////////////////////////////////////////////////////////////
    // Idle start, empty array
    initial begin
        a = '{default: 8'h00};
        {col, stat_mode, fail, na} = '0;
        busy_until = 0;
        {io_bus_out, io_bus_oe_out, rb_low_out} = '0;
    end
    // Busy runs on its own, chip select has no say
    always #5 rb_low_out = ($realtime < busy_until);
    // Unwritten bytes read back as column xor row
    function automatic logic [7:0] byte_at(input logic [11:0] c);
        int k;
        k = {a[3], a[2], c};
        return arr.exists(k) ? arr[k] : c[7:0] ^ a[2];
    endfunction : byte_at
    ////////////////////////////////////////////////////////////////
    // Command, address and data capture
    always @(posedge we_n_in) begin
        if (!ce_n_in && cle_in && (!rb_low_out || io_bus_in inside {8'hff, 8'h70})) begin
            na = 0;
            stat_mode = (io_bus_in == 8'h70);
            case (io_bus_in)
                8'hff: begin
                    busy_until = rb_low_out ? $realtime + 200 : 0;
                    fail = 1'b0;
                    pend.delete();
                end
                8'h30: busy_until = $realtime + BUSY_NS;
                8'he0: col = {a[1][3:0], a[0]};
                8'h10, 8'hd0: begin
                    fail = !wp_n_in;
                    if (wp_n_in) begin
                        foreach (pend[k]) arr[k] = pend[k];
                        busy_until = $realtime + BUSY_NS;
                    end
                    pend.delete();
                end
                default: ;
            endcase
        end else if (!ce_n_in && ale_in && !rb_low_out) begin
            a[na[1:0]] = io_bus_in;
            na = na + 1;
            col = {a[1][3:0], a[0]};
        end else if (!ce_n_in && !cle_in && !rb_low_out) begin
            pend[{a[3], a[2], col}] = io_bus_in;
            col = col + 1;
        end
    end
    // Read strobe fall drives one byte
    always @(negedge read_strobe_n_in) begin
        if (!ce_n_in && !rb_low_out) begin
            io_bus_out = stat_mode ? {wp_n_in, 1'b1, 5'h00, fail} : byte_at(col);
            io_bus_oe_out = 1'b1;
            col = stat_mode ? col : col + 1;
        end
    end
    // Release, leaving a changed pattern behind
    always @(posedge read_strobe_n_in or posedge ce_n_in) begin
        if (io_bus_oe_out) begin
            io_bus_oe_out = 1'b0;
            io_bus_out = ~io_bus_out;
        end
    end
endmodule : nbf_dev_model

// ==== tb/test_nbf_host.sv ====
// Self-checking bench of the NAND host controller against the device model.
// Assumes the package and device model are compiled first.
`timescale 1ns/1ps
module test_nbf_host;
    logic clk_sys_in = 0;
    logic reset_in = 1;
    logic [4:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 0;
    logic rd = 0;
    logic rdy = 0;
    logic saw_busy = 0;
    logic [31:0] rdata, got;
    logic [7:0] rd_data, io_wire, dev_io, host_o;
    logic rd_valid, cle, ale, ce_n, we_n, re_n, wp_n, host_oe, dev_oe, rb_low;
    int fail_count = 0;
    int n_tests = 0;
    ////////////////////////////////////////////////////////////////
    always #12.5 clk_sys_in = ~clk_sys_in;
    // Io wire and pulled-up ready/busy
    assign io_wire = host_oe ? host_o : dev_io;
    nbf_host i_nbf_host (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(1'b1), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .rd_ready_in(rdy), .cle_out(cle), .ale_out(ale), .ce_n_out(ce_n), .we_n_out(we_n),
        .read_strobe_n_out(re_n), .wp_n_out(wp_n), .ready_busy_n_in(!rb_low), .io_bus_in(io_wire),
        .io_bus_out(host_o), .io_bus_oe_out(host_oe));
    nbf_dev_model i_nbf_dev_model (.cle_in(cle), .ale_in(ale), .ce_n_in(ce_n), .we_n_in(we_n),
        .read_strobe_n_in(re_n), .wp_n_in(wp_n), .io_bus_in(io_wire), .io_bus_out(dev_io),
        .io_bus_oe_out(dev_oe), .rb_low_out(rb_low));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic wr_wdata(input logic [31:0] d);
        do rd_reg(nbf_pkg::OFS_STAT, got); while (got[nbf_pkg::STAT_WPEND_BIT] !== 1'b0);
        wr_reg(nbf_pkg::OFS_WDATA, d);
    endtask : wr_wdata
    // Poll until the sequencer is idle, noting a busy device
    task automatic wait_idle;
        saw_busy = 1'b0;
        for (int i = 0; i < 400; i++) begin
            rd_reg(nbf_pkg::OFS_STAT, got);
            saw_busy = saw_busy | !got[nbf_pkg::STAT_RB_BIT];
            if (got[nbf_pkg::STAT_BUSY_BIT] === 1'b0) break;
        end
        check({31'h0, got[nbf_pkg::STAT_BUSY_BIT]}, 32'h0);
    endtask : wait_idle
    // Take one stream byte and compare it
    task automatic pop(input logic [7:0] e);
        @(posedge clk_sys_in);
        #1;
        for (int i = 0; i < 400 && rd_valid !== 1'b1; i++) #25;
        check({23'h0, rd_valid, rd_data}, {23'h0, 1'b1, e});
        @(posedge clk_sys_in);
        rdy <= 1'b1;
        @(posedge clk_sys_in);
        rdy <= 1'b0;
    endtask : pop
    task automatic report_and_stop;
        $display("%0d compares, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////
    // Pin discipline at each read strobe fall, no contention
    always @(negedge re_n) check({27'h0, ce_n, cle, ale, we_n, host_oe}, 32'h2);
    always @(posedge clk_sys_in) if (host_oe && dev_oe) check(32'h1, 32'h0);
    initial begin
        #2000000;
        fail_count++;
        report_and_stop();
    end
    // Test sequence
    initial begin
        repeat (10) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        rd_reg(nbf_pkg::OFS_CTRL, got);
        check(got, 32'h0);
        rd_reg(5'h1c, got);
        check(got, 32'h0);
        wr_reg(nbf_pkg::OFS_OP, 32'h3);
        pop(8'h40);
        wait_idle();
        wr_reg(nbf_pkg::OFS_OP, 32'h4);
        rd_reg(nbf_pkg::OFS_STAT, got);
        check({31'h0, got[nbf_pkg::STAT_REFUSED_BIT]}, 32'h1);
        wr_reg(nbf_pkg::OFS_STAT, 32'h400);
        wr_reg(nbf_pkg::OFS_OP, 32'h6);
        rd_reg(nbf_pkg::OFS_STAT, got);
        check({31'h0, got[nbf_pkg::STAT_REFUSED_BIT]}, 32'h1);
        wr_reg(nbf_pkg::OFS_STAT, 32'h400);
        $display("reset, status and refusals done");
        wr_reg(nbf_pkg::OFS_CTRL, 32'h1);
        wr_reg(nbf_pkg::OFS_COL, 32'h7fe);
        wr_reg(nbf_pkg::OFS_ROW, 32'h0a45);
        wr_reg(nbf_pkg::OFS_LEN, 32'h2);
        wr_reg(nbf_pkg::OFS_OP, 32'h4);
        wr_wdata(32'h5a);
        wr_wdata(32'ha5);
        wait_idle();
        check({31'h0, saw_busy}, 32'h1);
        wr_reg(nbf_pkg::OFS_OP, 32'h3);
        pop(8'hc0);
        wait_idle();
        $display("program done");
        wr_reg(nbf_pkg::OFS_LEN, 32'h3);
        wr_reg(nbf_pkg::OFS_OP, 32'h1);
        repeat (200) @(posedge clk_sys_in);
        rd_reg(nbf_pkg::OFS_STAT, got);
        check({31'h0, got[nbf_pkg::STAT_BUSY_BIT]}, 32'h1);
        pop(8'h5a);
        pop(8'ha5);
        pop(8'h45);
        wait_idle();
        $display("page read with stall done");
        wr_reg(nbf_pkg::OFS_COL, 32'h7ff);
        wr_reg(nbf_pkg::OFS_LEN, 32'h1);
        wr_reg(nbf_pkg::OFS_OP, 32'h2);
        pop(8'ha5);
        wait_idle();
        wr_reg(nbf_pkg::OFS_OP, 32'h5);
        repeat (40) @(posedge clk_sys_in);
        wr_reg(nbf_pkg::OFS_OP, 32'h1);
        rd_reg(nbf_pkg::OFS_STAT, got);
        check({31'h0, got[nbf_pkg::STAT_REFUSED_BIT]}, 32'h1);
        wait_idle();
        check({31'h0, saw_busy}, 32'h1);
        wr_reg(nbf_pkg::OFS_OP, 32'h0);
        wait_idle();
        wr_reg(nbf_pkg::OFS_OP, 32'h3);
        pop(8'hc0);
        wait_idle();
        $display("random out, erase and reset done");
        report_and_stop();
    end
endmodule : test_nbf_host
